/* fpc_compensator.sv */
// Functional notes
// RULE_01: type select picks gas, liquid, or either without the square root.
// RULE_02: inputs accepted from -102.00 to +102.00 percent in hundredths.
// RULE_03: compensated flow held between -2 and +102 percent.
// RULE_04: input C is low-range flow, input D is high-range flow.
// RULE_05: low-range limit 0..100.00 percent; high flow above it is used.
// RULE_06: otherwise the low-range flow is used.
// RULE_07: pressure or gravity on input A, temperature on input B.
// RULE_08: absolute value = zero offset plus span times percent over 100.
// RULE_09: gas factor is P/T times K over (A*P + B*T + C).
// RULE_10: liquid factor is (A + B*Tr + C*Tr^2) over K, Tr = T/Tc.
// RULE_11: one coefficient is pressure offset for gas, critical temp for liquid.
// RULE_12: temperature offset must include 273.15 or 459.67 from software.
// RULE_13: gage pressure needs atmosphere added to the offset by software.
// RULE_14: ideal gas wants A and B zero and C one.
// RULE_15: flow input must already be linear.
// RULE_16: stores a class word, eight real coefficients and four input links.
// RULE_17: saturated steam uses liquid mode with pressure on input B.
//
// Our own choices: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/10ps
`include "fpc_defs.svh"
module fpc_compensator
  import fpc_pkg::*;
(
  input wire logic I_REF_CLK,
  input wire logic I_RST_B,
  input wire logic [3:0] I_AVS_ADDRESS,
  input wire logic I_AVS_READ,
  input wire logic I_AVS_WRITE,
  input wire logic [31:0] I_AVS_WRITEDATA,
  input wire logic [3:0] I_AVS_BYTEENABLE,
  output logic [31:0] O_AVS_READDATA,
  output logic O_AVS_WAITREQUEST,
  input wire logic I_SCAN_START,
  input wire logic signed [15:0] I_PRESSURE,
  input wire logic signed [15:0] I_TEMPERATURE,
  input wire logic signed [15:0] I_LOW_RANGE_FLOW,
  input wire logic signed [15:0] I_HIGH_RANGE_FLOW,
  output logic signed [15:0] O_COMP_FLOW,
  output logic O_FLOW_VALID,
  output logic O_BUSY
);

  localparam fpc_regs_t RST_VAL = '{
    st: FPC_IDLE,
    wreq: 1'b1,
    type_sel: FPC_GAS,
    mode: FPC_GAS,
    coef: '{7: `FPC_RST_KK, 6: `FPC_RST_CC, 2: `FPC_RST_TO, 0: `FPC_RST_PO,
      default: 32'h0},
    default: '0
  };

  fpc_regs_t s_q;
  fpc_regs_t s_d;

  // saturate a wide value into Q16.16
  function automatic logic signed [31:0] sat32(input logic signed [63:0] v);
    if (v > 64'sh0000_0000_7FFF_FFFF)
      sat32 = 32'sh7FFF_FFFF;
    else if (v < 64'shFFFF_FFFF_8000_0000)
      sat32 = 32'sh8000_0000;
    else
      sat32 = v[31:0];
  endfunction

  // Q16.16 product
  function automatic logic signed [31:0] qmul(input logic signed [31:0] a,
    input logic signed [31:0] b);
    logic signed [63:0] m;
    m = 64'(a) * 64'(b);
    qmul = sat32(m >>> 16);
  endfunction

  // offset plus span times percent over 100, percent given in hundredths
  function automatic logic signed [31:0] conv(input logic signed [31:0] off,
    input logic signed [31:0] span, input logic signed [15:0] pct);
    logic signed [79:0] w;
    w = 80'(span) * 80'(pct) * $signed({60'h0, `FPC_RECIP_1E4});
    conv = sat32(64'(off) + 64'(w >>> 32)); // RULE_08
  endfunction

  // clip a percent figure into a window
  function automatic logic signed [15:0] clip(input logic signed [15:0] v,
    input logic signed [15:0] lo, input logic signed [15:0] hi);
    clip = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // divider result with sign, saturated; zero divisor gives full scale
  function automatic logic signed [31:0] divres(input logic [47:0] q,
    input logic neg, input logic dz);
    logic signed [31:0] mag;
    mag = (dz || q > 48'h0000_7FFF_FFFF) ? 32'sh7FFF_FFFF : $signed(q[31:0]);
    divres = neg ? -mag : mag;
  endfunction

  // register map merged into one write path, byte lanes honoured
  function automatic logic [31:0] merge(input logic [31:0] old,
    input logic [31:0] wd, input logic [3:0] be);
    for (int i = 0; i < 4; i++)
    begin
      merge[i*8 +: 8] = be[i] ? wd[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  assign O_AVS_READDATA = s_q.rdata;
  assign O_AVS_WAITREQUEST = s_q.wreq;
  assign O_COMP_FLOW = s_q.flow;
  assign O_FLOW_VALID = s_q.valid;
  assign O_BUSY = s_q.busy;

  // whole next-state computation: bus slave and the scan sequencer
  always_comb
  begin
    logic [31:0] rd;
    logic [31:0] wv;
    logic [15:0] lv;
    logic signed [15:0] hi;
    logic signed [15:0] lo;
    logic signed [31:0] pv;
    logic signed [31:0] tv;
    logic signed [31:0] dnum;
    logic signed [31:0] dden;
    logic dgo;
    logic [32:0] tmp;
    logic [47:0] ndq;
    logic [23:0] trial;
    logic signed [63:0] prod;
    logic signed [63:0] acc;
    rd = 32'h0;
    wv = 32'h0;
    lv = 16'h0;
    hi = 16'sh0;
    lo = 16'sh0;
    pv = 32'sh0;
    tv = 32'sh0;
    dnum = 32'sh0;
    dden = 32'sh0;
    dgo = 1'b0;
    tmp = 33'h0;
    ndq = 48'h0;
    trial = 24'h0;
    prod = 64'sh0;
    acc = 64'sh0;
    s_d = s_q;
    s_d.valid = 1'b0;

    // read mux; unmapped words read as zero
    if (I_AVS_ADDRESS == `FPC_REG_CTRL)
      rd = {30'h0, s_q.type_sel};
    else if (I_AVS_ADDRESS == `FPC_REG_LOLIM)
      rd = {16'h0, s_q.ll};
    else if (I_AVS_ADDRESS >= `FPC_REG_COEF_FIRST && I_AVS_ADDRESS <= `FPC_REG_COEF_LAST)
      rd = s_q.coef[3'(I_AVS_ADDRESS - `FPC_REG_COEF_FIRST)];
    else if (I_AVS_ADDRESS == `FPC_REG_LINK_AB)
      rd = {s_q.link[1], s_q.link[0]};
    else if (I_AVS_ADDRESS == `FPC_REG_LINK_CD)
      rd = {s_q.link[3], s_q.link[2]};
    else if (I_AVS_ADDRESS == `FPC_REG_STATUS)
      rd = {29'h0, s_q.mode, s_q.busy};
    else if (I_AVS_ADDRESS == `FPC_REG_RESULT)
      rd = {{16{s_q.flow[15]}}, s_q.flow};

    // one wait cycle, then the access completes at the next edge
    if ((I_AVS_READ || I_AVS_WRITE) && s_q.wreq)
    begin
      s_d.wreq = 1'b0;
      s_d.rdata = rd;
    end
    else if (!s_q.wreq)
    begin
      s_d.wreq = 1'b1;
      if (I_AVS_WRITE)
      begin
        wv = merge(rd, I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
        lv = wv[15:0];
        if (I_AVS_ADDRESS == `FPC_REG_CTRL)
          s_d.type_sel = fpc_mode_t'(wv[1:0]); // RULE_01
        else if (I_AVS_ADDRESS == `FPC_REG_LOLIM)
          s_d.ll = (lv > `FPC_LOLIM_MAX) ? `FPC_LOLIM_MAX : lv; // RULE_05
        else if (I_AVS_ADDRESS >= `FPC_REG_COEF_FIRST &&
          I_AVS_ADDRESS <= `FPC_REG_COEF_LAST)
          s_d.coef[3'(I_AVS_ADDRESS - `FPC_REG_COEF_FIRST)] = wv; // RULE_16
        else if (I_AVS_ADDRESS == `FPC_REG_LINK_AB)
          {s_d.link[1], s_d.link[0]} = wv; // RULE_16
        else if (I_AVS_ADDRESS == `FPC_REG_LINK_CD)
          {s_d.link[3], s_d.link[2]} = wv;
      end
    end

    // scan sequencer, one evaluation per start pulse
    unique case (s_q.st)
      FPC_IDLE:
      begin
        if (I_SCAN_START)
        begin
          hi = clip(I_HIGH_RANGE_FLOW, `FPC_PCT_MIN, `FPC_PCT_MAX); // RULE_04
          lo = clip(I_LOW_RANGE_FLOW, `FPC_PCT_MIN, `FPC_PCT_MAX); // RULE_02
          s_d.pa = clip(I_PRESSURE, `FPC_PCT_MIN, `FPC_PCT_MAX); // RULE_07
          s_d.pb = clip(I_TEMPERATURE, `FPC_PCT_MIN, `FPC_PCT_MAX);
          if (hi > $signed(s_q.ll)) // RULE_05
            s_d.qf = hi;
          else
            s_d.qf = lo; // RULE_06
          // mode is frozen for the whole scan so a bus write cannot split it
          s_d.mode = s_q.type_sel;
          s_d.busy = 1'b1;
          s_d.st = FPC_CONV;
        end
      end
      FPC_CONV:
      begin
        pv = conv(s_q.coef[`FPC_C_PO], s_q.coef[`FPC_C_AP], s_q.pa); // RULE_08
        tv = conv(s_q.coef[`FPC_C_TO], s_q.coef[`FPC_C_AT], s_q.pb);
        s_d.p = pv;
        s_d.t = tv;
        s_d.second = 1'b0;
        dgo = 1'b1;
        if (s_q.mode[0] == 1'b0)
        begin
          dnum = qmul(pv, s_q.coef[`FPC_C_KK]); // RULE_09
          dden = tv;
        end
        else
        begin
          // offset slot reused as critical temperature
          dnum = tv; // RULE_10
          dden = s_q.coef[`FPC_C_PO]; // RULE_11
        end
      end
      FPC_DIV:
      begin
        // restoring division, one quotient bit per clock
        tmp = {s_q.rem[31:0], s_q.dq[47]};
        ndq = {s_q.dq[46:0], 1'b0};
        if (tmp >= {1'b0, s_q.dabs})
        begin
          tmp = tmp - {1'b0, s_q.dabs};
          ndq[0] = 1'b1;
        end
        s_d.rem = tmp;
        s_d.dq = ndq;
        s_d.cnt = s_q.cnt - 6'h1;
        if (s_q.cnt == 6'h1)
        begin
          s_d.quo = divres(ndq, s_q.neg, s_q.dz);
          s_d.st = s_q.second ? FPC_FIN : FPC_MID;
        end
      end
      FPC_MID:
      begin
        s_d.second = 1'b1;
        dgo = 1'b1;
        // stored coefficients are raw bits; sign them before widening or a negative one turns huge
        if (s_q.mode[0] == 1'b0)
        begin
          acc = 64'(qmul(s_q.coef[`FPC_C_CA], s_q.p)) +
            64'(qmul(s_q.coef[`FPC_C_CB], s_q.t)) + 64'($signed(s_q.coef[`FPC_C_CC]));
          dnum = s_q.quo; // RULE_09
          dden = sat32(acc);
        end
        else
        begin
          acc = 64'($signed(s_q.coef[`FPC_C_CA])) + 64'(qmul(s_q.coef[`FPC_C_CB], s_q.quo)) +
            64'(qmul(s_q.coef[`FPC_C_CC], qmul(s_q.quo, s_q.quo)));
          dnum = sat32(acc); // RULE_10
          dden = s_q.coef[`FPC_C_KK];
        end
      end
      FPC_FIN:
      begin
        if (s_q.mode == FPC_GAS || s_q.mode == FPC_LIQ) // RULE_01
        begin
          // a negative factor has no root; treat it as zero flow
          s_d.dq = s_q.quo[31] ? 48'h0 : {s_q.quo[31:0], 16'h0};
          s_d.root = 24'h0;
          s_d.cnt = `FPC_ROOT_STEPS;
          s_d.st = FPC_ROOT;
        end
        else
        begin
          s_d.fac = s_q.quo; // RULE_01
          s_d.st = FPC_OUT;
        end
      end
      FPC_ROOT:
      begin
        // bitwise square root, most significant bit first
        trial = s_q.root | (24'h1 << (s_q.cnt - 6'h1));
        if (48'(trial) * 48'(trial) <= s_q.dq)
          s_d.root = trial;
        s_d.cnt = s_q.cnt - 6'h1;
        if (s_q.cnt == 6'h1)
        begin
          s_d.fac = $signed({8'h00, s_d.root});
          s_d.st = FPC_OUT;
        end
      end
      FPC_OUT:
      begin
        prod = 64'(s_q.qf) * 64'(s_q.fac); // RULE_15
        prod = prod >>> 16;
        if (prod < 64'(`FPC_OUT_MIN))
          s_d.flow = `FPC_OUT_MIN; // RULE_03
        else if (prod > 64'(`FPC_OUT_MAX))
          s_d.flow = `FPC_OUT_MAX; // RULE_03
        else
          s_d.flow = prod[15:0];
        s_d.valid = 1'b1;
        s_d.busy = 1'b0;
        s_d.st = FPC_IDLE;
      end
      // the eighth state code is unused; fall back to idle rather than hang busy
      default:
      begin
        s_d.st = FPC_IDLE;
        s_d.busy = 1'b0;
      end
    endcase

    // shared divider launch, quotient is numerator over denominator in Q16.16
    if (dgo)
    begin
      s_d.dq = {(dnum[31] ? 32'(-dnum) : 32'(dnum)), 16'h0};
      s_d.dabs = dden[31] ? 32'(-dden) : 32'(dden);
      s_d.neg = dnum[31] ^ dden[31];
      s_d.dz = (dden == 32'sh0);
      s_d.rem = 33'h0;
      s_d.cnt = `FPC_DIV_STEPS;
      s_d.st = FPC_DIV;
    end
  end

  // all state in one register bank
  always_ff @(posedge I_REF_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
      s_q <= RST_VAL;
    else
      s_q <= s_d;
  end

endmodule // fpc_compensator

/* fpc_defs.svh */
`ifndef FPC_DEFS_SVH
`define FPC_DEFS_SVH
// word offsets on the register bus
`define FPC_REG_CTRL 4'h0
`define FPC_REG_LOLIM 4'h1
`define FPC_REG_COEF_FIRST 4'h2
`define FPC_REG_COEF_LAST 4'h9
`define FPC_REG_LINK_AB 4'hA
`define FPC_REG_LINK_CD 4'hB
`define FPC_REG_STATUS 4'hC
`define FPC_REG_RESULT 4'hD
// coefficient slots
`define FPC_C_PO 3'd0
`define FPC_C_AP 3'd1
`define FPC_C_TO 3'd2
`define FPC_C_AT 3'd3
`define FPC_C_CA 3'd4
`define FPC_C_CB 3'd5
`define FPC_C_CC 3'd6
`define FPC_C_KK 3'd7
// reset values, Q16.16
`define FPC_RST_PO 32'h0001_0000
`define FPC_RST_TO 32'h0111_2666
`define FPC_RST_CC 32'h0001_0000
`define FPC_RST_KK 32'h0111_2666
// percent figures in hundredths
`define FPC_PCT_MAX 16'sh27D8
`define FPC_PCT_MIN 16'shD828
`define FPC_OUT_MIN 16'shFF38
`define FPC_OUT_MAX 16'sh27D8
`define FPC_LOLIM_MAX 16'h2710
// 2^32 / 10000, turns hundredths of percent into a fraction
`define FPC_RECIP_1E4 20'h68DB9
// iteration counts
`define FPC_DIV_STEPS 6'h30
`define FPC_ROOT_STEPS 6'h18
`endif

/* fpc_pkg.sv */
package fpc_pkg;
  typedef enum logic [1:0] {FPC_GAS, FPC_LIQ, FPC_GAS_LIN, FPC_LIQ_LIN} fpc_mode_t;
  typedef enum logic [2:0] {FPC_IDLE, FPC_CONV, FPC_DIV, FPC_MID, FPC_FIN, FPC_ROOT,
    FPC_OUT} fpc_state_t;
  typedef struct packed {
    fpc_state_t st;
    logic wreq;
    logic [31:0] rdata;
    fpc_mode_t type_sel;
    fpc_mode_t mode;
    logic [15:0] ll;
    logic [7:0][31:0] coef;
    logic [3:0][15:0] link;
    logic signed [15:0] pa;
    logic signed [15:0] pb;
    logic signed [15:0] qf;
    logic signed [15:0] flow;
    logic signed [31:0] p;
    logic signed [31:0] t;
    logic signed [31:0] quo;
    logic signed [31:0] fac;
    logic [47:0] dq;
    logic [32:0] rem;
    logic [31:0] dabs;
    logic neg;
    logic dz;
    logic second;
    logic [5:0] cnt;
    logic [23:0] root;
    logic valid;
    logic busy;
  } fpc_regs_t;
endpackage

/* fpc_compensator_asserts.sv */
`timescale 1ns/10ps
`include "fpc_defs.svh"
module fpc_compensator_asserts (
  input wire logic I_REF_CLK,
  input wire logic I_RST_B,
  input wire logic [3:0] I_AVS_ADDRESS,
  input wire logic I_AVS_READ,
  input wire logic I_AVS_WRITE,
  input wire logic [31:0] O_AVS_READDATA,
  input wire logic O_AVS_WAITREQUEST,
  input wire logic I_SCAN_START,
  input wire logic signed [15:0] O_COMP_FLOW,
  input wire logic O_FLOW_VALID,
  input wire logic O_BUSY
);
  default clocking cb @(posedge I_REF_CLK);
  endclocking
  default disable iff (!I_RST_B);
  // scan answer, linear types skip the root stage
  sequence s_lin;
    ##100 O_FLOW_VALID;
  endsequence
  sequence s_root;
    ##124 O_FLOW_VALID;
  endsequence
  // bus answers after one wait cycle and the answer stands one cycle
  property p_wait_one;
    (I_AVS_READ || I_AVS_WRITE) && O_AVS_WAITREQUEST |=>
      !O_AVS_WAITREQUEST ##1 O_AVS_WAITREQUEST;
  endproperty
  property p_wait_idle;
    !I_AVS_READ && !I_AVS_WRITE |=> O_AVS_WAITREQUEST;
  endproperty
  property p_unmapped;
    I_AVS_READ && O_AVS_WAITREQUEST && I_AVS_ADDRESS > 4'hD |=> O_AVS_READDATA == 32'h0;
  endproperty
  property p_range;
    O_COMP_FLOW >= `FPC_OUT_MIN && O_COMP_FLOW <= `FPC_OUT_MAX;
  endproperty
  // start is taken only when idle, then the fixed latency follows
  property p_start;
    I_SCAN_START && !O_BUSY |=> O_BUSY;
  endproperty
  property p_latency;
    $rose(O_BUSY) |-> s_lin or s_root;
  endproperty
  property p_valid_end;
    O_FLOW_VALID |-> $fell(O_BUSY) ##1 !O_FLOW_VALID;
  endproperty
  // result must not drift between updates
  property p_flow_hold;
    !O_FLOW_VALID |-> $stable(O_COMP_FLOW);
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("bus answer timing wrong");
  a_wait_idle: assert property (p_wait_idle) else $error("waitrequest low without request");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_range: assert property (p_range) else $error("flow out of range");
  a_start: assert property (p_start) else $error("start not taken");
  a_latency: assert property (p_latency) else $error("scan latency wrong");
  a_valid_end: assert property (p_valid_end) else $error("valid and busy disagree");
  a_flow_hold: assert property (p_flow_hold) else $error("flow changed without valid");
endmodule // fpc_compensator_asserts
bind fpc_compensator fpc_compensator_asserts u_chk (
  .I_REF_CLK, .I_RST_B, .I_AVS_ADDRESS, .I_AVS_READ, .I_AVS_WRITE, .O_AVS_READDATA,
  .O_AVS_WAITREQUEST, .I_SCAN_START, .O_COMP_FLOW, .O_FLOW_VALID, .O_BUSY);

/* fpc_upstream_model.sv */
`timescale 1ns/10ps
module fpc_upstream_model (
  input wire logic i_clk,
  input wire logic i_go,
  input wire logic signed [15:0] i_a,
  input wire logic signed [15:0] i_b,
  input wire logic signed [15:0] i_c,
  input wire logic signed [15:0] i_d,
  output logic o_start,
  output logic signed [15:0] o_a,
  output logic signed [15:0] o_b,
  output logic signed [15:0] o_c,
  output logic signed [15:0] o_d
);
  // inputs are only valid in the start cycle; elsewhere they toggle so stale use shows
  initial
  begin
    o_start = 1'b0;
    {o_a, o_b, o_c, o_d} = 64'h0;
  end
  always @(posedge i_clk)
  begin
    o_start <= i_go;
    o_a <= i_go ? i_a : ~o_a;
    o_b <= i_go ? i_b : ~o_b;
    o_c <= i_go ? i_c : ~o_c;
    o_d <= i_go ? i_d : ~o_d;
  end
endmodule // fpc_upstream_model

/* flow_pressure_temp_compensator_test.sv */
`timescale 1ns/10ps
`include "fpc_defs.svh"
module flow_pressure_temp_compensator_test;
  import fpc_pkg::*;
  logic clk, rst_b, rd, wr, go, st, valid, busy, wreq;
  logic [3:0] adr, be;
  logic [31:0] wd, rdat;
  logic signed [15:0] a, b, c, d, pa, pb, pc, pd, flow, q;
  int fails, tests_run, cyc;
  fpc_upstream_model u_src (.i_clk(clk), .i_go(go), .i_a(a), .i_b(b), .i_c(c), .i_d(d),
    .o_start(st), .o_a(pa), .o_b(pb), .o_c(pc), .o_d(pd));
  fpc_compensator DUT (.I_REF_CLK(clk), .I_RST_B(rst_b), .I_AVS_ADDRESS(adr),
    .I_AVS_READ(rd), .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wd), .I_AVS_BYTEENABLE(be),
    .O_AVS_READDATA(rdat), .O_AVS_WAITREQUEST(wreq), .I_SCAN_START(st), .I_PRESSURE(pa),
    .I_TEMPERATURE(pb), .I_LOW_RANGE_FLOW(pc), .I_HIGH_RANGE_FLOW(pd), .O_COMP_FLOW(flow),
    .O_FLOW_VALID(valid), .O_BUSY(busy));
  // free running clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // a hung handshake would otherwise run forever
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      fails++;
      report_and_stop;
    end
  end
  task automatic report_and_stop;
    if (fails == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // fixed point math loses a few lsb, so results compare within a tolerance
  task automatic chk(input logic signed [31:0] got, input logic signed [31:0] exp, input int tol);
    logic signed [32:0] df;
    df = got - exp;
    tests_run++;
    if ((^got === 1'bx) || df > tol || df < -tol)
    begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      fails++;
    end
  endtask
  // one bus access, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] ad, input logic [31:0] dv,
    input logic [3:0] bv, output logic [31:0] r);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    adr <= ad;
    wd <= dv;
    be <= bv;
    do @(posedge clk); while (wreq !== 1'b0);
    r = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic wr32(input logic [3:0] ad, input logic [31:0] dv);
    logic [31:0] r;
    bus(1'b1, ad, dv, 4'hF, r);
  endtask
  // one evaluation through the upstream model, then compare the result
  task automatic scan(input logic signed [15:0] va, vc, vd, input logic signed [15:0] exp);
    int n;
    @(posedge clk);
    a <= va;
    b <= q;
    c <= vc;
    d <= vd;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    n = 0;
    do begin @(posedge clk); n++; end while (valid !== 1'b1 && n < 300);
    chk(flow, exp, 4);
    // busy must have dropped in the edge that raised valid, else the scan hung
    chk({busy, valid}, 32'h1, 0);
  endtask
  task automatic t_reset;
    logic [3:0] ra [7] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'h9, 4'hE};
    logic [31:0] rv [7] = '{32'h0, 32'h0, `FPC_RST_PO, `FPC_RST_TO, `FPC_RST_CC, `FPC_RST_KK,
      32'h0};
    logic [31:0] r;
    chk({flow, busy, valid, wreq}, 32'h1, 0);
    wr32(4'hE, 32'hFFFF_FFFF);
    for (int i = 0; i < 7; i++)
    begin
      bus(1'b0, ra[i], 32'h0, 4'hF, r);
      chk(r, rv[i], 0);
    end
  endtask
  task automatic t_lolim;
    logic [31:0] r;
    wr32(`FPC_REG_LOLIM, 32'h0000_3000);
    bus(1'b0, `FPC_REG_LOLIM, 32'h0, 4'hF, r);
    chk(r, {16'h0, `FPC_LOLIM_MAX}, 0);
    bus(1'b1, `FPC_REG_LOLIM, 32'hABCD_1388, 4'h3, r);
  endtask
  // low limit is 50.00 percent now; ideal gas defaults give a factor of one
  task automatic t_select;
    wr32(4'h6, 32'h0);
    wr32(4'h8, 32'h0001_0000);
    scan(16'sh0, 16'sh0FA0, 16'sh1770, 16'sh1770);
    scan(16'sh0, 16'sh0FA0, 16'sh1388, 16'sh0FA0);
  endtask
  // pressure span 1.0 and full input doubles absolute pressure
  task automatic t_gas;
    // kelvin offset kept; a zero of one stands for a gage zero plus the atmosphere
    wr32(4'h4, `FPC_RST_TO);
    wr32(4'h2, 32'h0001_0000);
    wr32(4'h3, 32'h0001_0000);
    scan(16'sh2710, 16'sh0FA0, 16'sh0, 16'sh1619);
    wr32(`FPC_REG_CTRL, 32'h2);
    scan(16'sh2710, 16'sh0FA0, 16'sh0, 16'sh1F40);
    scan(16'sh2710, 16'sh1770, 16'sh0, `FPC_OUT_MAX);
    scan(16'sh0, 16'shEC78, 16'sh0, `FPC_OUT_MIN);
  endtask
  // density linear in reduced temperature; critical temp 2.0 halves it
  task automatic t_liq;
    logic [31:0] r;
    wr32(4'h8, 32'h0);
    wr32(4'h7, 32'h0001_0000);
    bus(1'b1, `FPC_REG_CTRL, 32'hFFFF_FF03, 4'h1, r);
    scan(16'sh2710, 16'sh0FA0, 16'sh0, 16'sh0FA0);
    wr32(4'h2, 32'h0002_0000);
    scan(16'sh0, 16'sh0FA0, 16'sh0, 16'sh07D0);
    wr32(`FPC_REG_CTRL, 32'h1);
    scan(16'sh0, 16'sh0FA0, 16'sh0, 16'sh0B0C);
  endtask
  // saturated steam: pressure on input B, liquid type, critical temp one, density 1.0*Tr
  // offset 10.0, span 20.0, K 10.0; input B over 102 percent must be clipped first
  task automatic t_steam;
    logic [31:0] r;
    wr32(`FPC_REG_CTRL, 32'h3);
    wr32(4'h2, 32'h0001_0000);
    wr32(4'h4, 32'h000A_0000);
    wr32(4'h5, 32'h0014_0000);
    wr32(4'h9, 32'h000A_0000);
    q = 16'sh1388;
    scan(16'sh2710, 16'sh0BB8, 16'sh0, 16'sh1770);
    q = 16'sh7FFF;
    scan(16'sh0, 16'sh0BB8, 16'sh0, 16'sh23A0);
    bus(1'b0, `FPC_REG_STATUS, 32'h0, 4'hF, r);
    chk(r, 32'h6, 0);
    bus(1'b0, `FPC_REG_RESULT, 32'h0, 4'hF, r);
    chk(r, 32'h0000_23A0, 4);
  endtask
  initial
  begin
    rst_b = 1'b0;
    {rd, wr, go} = 3'h0;
    {a, b, c, d, q} = 80'h0;
    adr = 4'h0;
    be = 4'hF;
    wd = 32'h0;
    {fails, tests_run, cyc} = '0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    t_reset;
    t_lolim;
    t_select;
    t_gas;
    t_liq;
    t_steam;
    report_and_stop;
  end
endmodule // flow_pressure_temp_compensator_test
